//--- hw/pcsa_pkg.sv
package pcsa_pkg;
  // register byte addresses on the wishbone bus
  localparam logic [7:0] ADDR_POWER_CONTROL_FLAGS = 8'h8e;
  localparam logic [7:0] ADDR_COUNTER_LOW_BYTE = 8'h02;
  localparam logic [7:0] ADDR_COUNTER_HIGH_LATCH = 8'h0a;
  localparam logic [7:0] ADDR_FILE_SELECT_POINTER = 8'h04;
  localparam logic [7:0] ADDR_INDIRECT_DATA_PORT = 8'h00;
  localparam logic [7:0] ADDR_BANK_CONTROL = 8'h03;
  localparam logic [7:0] ADDR_PC_STATUS_LOW = 8'h10;
  localparam logic [7:0] ADDR_PC_STATUS_HIGH = 8'h14;
  // power control field positions and reset values
  localparam int unsigned PCF_BOREN_BIT = 4;
  localparam int unsigned PCF_POR_BIT = 1;
  localparam int unsigned PCF_BOR_BIT = 0;
  localparam logic [7:0] PCF_WRITE_MASK = 8'h13;
  localparam logic SOFT_BOREN_RESET = 1'b1;
  // bank register: indirect bank bit position
  localparam int unsigned BANK_IRP_BIT = 7;
  // widths
  localparam int unsigned PC_W = 13;
  localparam int unsigned STACK_DEPTH = 8;
  localparam int unsigned SP_W = 3;
  localparam int unsigned JUMP_W = 11;
  localparam int unsigned DADDR_W = 9;
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;

  typedef enum logic [6:0] {
    PCSA_OP_NONE = 7'h01,
    PCSA_OP_STEP = 7'h02,
    PCSA_OP_JUMP = 7'h04,
    PCSA_OP_CALL = 7'h08,
    PCSA_OP_IRQ = 7'h10,
    PCSA_OP_RET = 7'h20,
    PCSA_OP_WRPCL = 7'h40
  } pcsa_op_e;

  typedef struct packed {
    pcsa_op_e op;
    logic [JUMP_W-1:0] target;
    logic [7:0] lowByte;
    logic [PC_W-1:0] vector;
  } pcsa_flow_s;

  typedef struct packed {
    logic [DADDR_W-1:0] addr;
    logic isIndirectPort;
  } pcsa_ind_s;
endpackage

//--- hw/pcsa_stack_mem.sv
`timescale 1ns/1ps
module pcsa_stack_mem (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // write side
  input wire logic wrEn,
  input wire logic [pcsa_pkg::SP_W-1:0] wrAddr,
  input wire logic [pcsa_pkg::PC_W-1:0] wrData,
  // read side
  input wire logic [pcsa_pkg::SP_W-1:0] rdAddr,
  output logic [pcsa_pkg::PC_W-1:0] rdData
);
  logic [pcsa_pkg::PC_W-1:0] mem [pcsa_pkg::STACK_DEPTH];
  logic [pcsa_pkg::PC_W-1:0] rdData_ff;

  always_ff @(posedge clk_sys) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdData_ff <= pcsa_pkg::PC_RESET;
    end else begin
      // a push into the slot being fetched shows its new value at once
      rdData_ff <= (wrEn && wrAddr == rdAddr) ? wrData : mem[rdAddr];
    end
  end

  assign rdData = rdData_ff;
endmodule // pcsa_stack_mem

//--- hw/pcsa_wb_slave.sv
`timescale 1ns/1ps
module pcsa_wb_slave (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic wb_sel_i,
  // access strobes to the register core
  output logic wrStrobe,
  output logic rdStrobe,
  output logic ackOut
);
  logic ack_ff;
  wire request = wb_cyc_i && wb_stb_i && wb_sel_i && !ack_ff;
  wire reqAny = wb_cyc_i && wb_stb_i && !ack_ff;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= reqAny;
    end
  end

  // one-cycle strobes, in the cycle before the ack register rises
  assign wrStrobe = request && wb_we_i;
  assign rdStrobe = request && !wb_we_i;
  assign ackOut = ack_ff;
endmodule // pcsa_wb_slave

//--- hw/pcsa_core.sv
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/1ps
module pcsa_core (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // reset cause pulses from the reset generator
  input wire logic porEvent,
  input wire logic borEvent,
  input wire logic watchdogResetEvent,
  input wire logic masterClearEvent,
  // instruction decoder flow request
  input wire logic flowValid,
  input wire pcsa_pkg::pcsa_flow_s flowReq,
  // indirect data memory side
  input wire logic [7:0] dataRdIn,
  output logic [pcsa_pkg::DADDR_W-1:0] dataAddr,
  output logic dataWrEn,
  output logic [7:0] dataWrOut,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // status out
  output logic [pcsa_pkg::PC_W-1:0] progCounter,
  output logic softBrownoutEnable
);
  logic [pcsa_pkg::PC_W-1:0] pc_ff, nxt_pc;
  logic [4:0] latch_ff;
  logic [7:0] fsr_ff;
  logic bank_ff;
  logic soft_brownout_enable_ff, porFlag_ff, borFlag_ff;
  logic [pcsa_pkg::SP_W-1:0] sp_ff, nxt_sp;
  logic [31:0] rdData_ff;
  logic dataWrEn_ff;
  logic [7:0] dataWrOut_ff;
  logic [pcsa_pkg::DADDR_W-1:0] dataAddr_ff;
  logic [pcsa_pkg::PC_W-1:0] stackTop;
  logic wrStrobe, rdStrobe, ackOut;
  logic pushEn;
  logic [pcsa_pkg::PC_W-1:0] pushData;

  pcsa_wb_slave u_bus (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_sel_i(wb_sel_i[0]),
    .wrStrobe(wrStrobe),
    .rdStrobe(rdStrobe),
    .ackOut(ackOut)
  );

  // address decode
  wire selPcon = wb_adr_i == pcsa_pkg::ADDR_POWER_CONTROL_FLAGS;
  wire selPcl = wb_adr_i == pcsa_pkg::ADDR_COUNTER_LOW_BYTE;
  wire selLatch = wb_adr_i == pcsa_pkg::ADDR_COUNTER_HIGH_LATCH;
  wire selFsr = wb_adr_i == pcsa_pkg::ADDR_FILE_SELECT_POINTER;
  wire selIndf = wb_adr_i == pcsa_pkg::ADDR_INDIRECT_DATA_PORT;
  wire selBank = wb_adr_i == pcsa_pkg::ADDR_BANK_CONTROL;
  wire selPcLo = wb_adr_i == pcsa_pkg::ADDR_PC_STATUS_LOW;
  wire selPcHi = wb_adr_i == pcsa_pkg::ADDR_PC_STATUS_HIGH;

  // indirect address: bank bit above pointer
  wire [pcsa_pkg::DADDR_W-1:0] indAddr = {bank_ff, fsr_ff};
  // pointer aimed at the port itself (either bank)
  wire indSelf = fsr_ff == pcsa_pkg::ADDR_INDIRECT_DATA_PORT;

  wire [7:0] pconRead = {3'h0, soft_brownout_enable_ff, 2'h0, porFlag_ff, borFlag_ff};
  wire [7:0] indRead = indSelf ? 8'h00 : dataRdIn;
  wire [7:0] bankRead = {bank_ff, 7'h00};
  wire [31:0] busRead =
    selPcon ? {24'h0, pconRead} :
    selPcl ? {24'h0, pc_ff[7:0]} :
    selLatch ? {27'h0, latch_ff} :
    selFsr ? {24'h0, fsr_ff} :
    selIndf ? {24'h0, indRead} :
    selBank ? {24'h0, bankRead} :
    selPcLo ? {24'h0, pc_ff[7:0]} :
    selPcHi ? {27'h0, pc_ff[12:8]} :
    32'h0;

  wire wPcon = wrStrobe && selPcon;
  wire wPcl = wrStrobe && selPcl;
  wire wLatch = wrStrobe && selLatch;
  wire wFsr = wrStrobe && selFsr;
  wire wIndf = wrStrobe && selIndf && !indSelf;
  wire wBank = wrStrobe && selBank;

  // flow decode
  wire opStep = flowValid && flowReq.op == pcsa_pkg::PCSA_OP_STEP;
  wire opJump = flowValid && flowReq.op == pcsa_pkg::PCSA_OP_JUMP;
  wire opCall = flowValid && flowReq.op == pcsa_pkg::PCSA_OP_CALL;
  wire opIrq = flowValid && flowReq.op == pcsa_pkg::PCSA_OP_IRQ;
  wire opRet = flowValid && flowReq.op == pcsa_pkg::PCSA_OP_RET;
  wire opWrPcl = flowValid && flowReq.op == pcsa_pkg::PCSA_OP_WRPCL;

  wire [pcsa_pkg::PC_W-1:0] pcInc = pc_ff + 13'h0001;
  wire [pcsa_pkg::PC_W-1:0] jumpDest = {latch_ff[4:3], flowReq.target};
  wire [pcsa_pkg::PC_W-1:0] pclDest = {latch_ff, flowReq.lowByte};
  wire [pcsa_pkg::PC_W-1:0] busPclDest = {latch_ff, wb_dat_i[7:0]};

  // call pushes the return address, interrupt the interrupted one
  assign pushEn = opCall || opIrq;
  assign pushData = opCall ? pcInc : pc_ff;

  // pointer to next free slot; top is slot below it
  wire [pcsa_pkg::SP_W-1:0] spTop = sp_ff - 3'h1;

  // memory prefetches the top for the pointer value after this edge
  wire resetEvent = porEvent || borEvent || watchdogResetEvent || masterClearEvent;
  wire [pcsa_pkg::SP_W-1:0] spLoad = resetEvent ? 3'h0 : nxt_sp;
  wire [pcsa_pkg::SP_W-1:0] spNextTop = spLoad - 3'h1;

  pcsa_stack_mem u_stack (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .wrEn(pushEn),
    .wrAddr(sp_ff),
    .wrData(pushData),
    .rdAddr(spNextTop),
    .rdData(stackTop)
  );

  always_comb begin
    nxt_pc = pc_ff;
    nxt_sp = sp_ff;
    if (opStep) begin
      nxt_pc = pcInc;
    end else if (opJump) begin
      nxt_pc = jumpDest;
    end else if (opCall || opIrq) begin
      nxt_pc = opCall ? jumpDest : flowReq.vector;
      nxt_sp = sp_ff + 3'h1;
    end else if (opRet) begin
      nxt_pc = stackTop;
      nxt_sp = spTop;
    end else if (opWrPcl) begin
      nxt_pc = pclDest;
    end else if (wPcl) begin
      nxt_pc = busPclDest;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pc_ff <= pcsa_pkg::PC_RESET;
      sp_ff <= 3'h0;
    end else if (porEvent || borEvent || watchdogResetEvent || masterClearEvent) begin
      pc_ff <= pcsa_pkg::PC_RESET;
      sp_ff <= 3'h0;
    end else begin
      pc_ff <= nxt_pc;
      sp_ff <= nxt_sp;
    end
  end

  // latch written only by software, never by stack traffic
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      latch_ff <= 5'h00;
    end else if (wLatch) begin
      latch_ff <= wb_dat_i[4:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fsr_ff <= 8'h00;
      bank_ff <= 1'b0;
    end else begin
      if (wFsr) begin
        fsr_ff <= wb_dat_i[7:0];
      end
      if (wBank) begin
        bank_ff <= wb_dat_i[pcsa_pkg::BANK_IRP_BIT];
      end
    end
  end

  // por clears both flags, bor clears its own; por or bor beats a software set, watchdog and master clear leave the flags alone
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      soft_brownout_enable_ff <= pcsa_pkg::SOFT_BOREN_RESET;
      porFlag_ff <= 1'b0;
      borFlag_ff <= 1'b0;
    end else if (porEvent) begin
      soft_brownout_enable_ff <= pcsa_pkg::SOFT_BOREN_RESET;
      porFlag_ff <= 1'b0;
      borFlag_ff <= 1'b0;
    end else if (borEvent) begin
      borFlag_ff <= 1'b0;
    end else if (wPcon) begin
      soft_brownout_enable_ff <= wb_dat_i[pcsa_pkg::PCF_BOREN_BIT];
      porFlag_ff <= wb_dat_i[pcsa_pkg::PCF_POR_BIT];
      borFlag_ff <= wb_dat_i[pcsa_pkg::PCF_BOR_BIT];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdData_ff <= 32'h0;
      dataWrEn_ff <= 1'b0;
      dataWrOut_ff <= 8'h00;
      dataAddr_ff <= 9'h000;
    end else begin
      if (rdStrobe) begin
        rdData_ff <= busRead;
      end
      dataWrEn_ff <= wIndf;
      dataWrOut_ff <= wb_dat_i[7:0];
      dataAddr_ff <= indAddr;
    end
  end

  assign wb_dat_o = rdData_ff;
  assign wb_ack_o = ackOut;
  assign dataAddr = dataAddr_ff;
  assign dataWrEn = dataWrEn_ff;
  assign dataWrOut = dataWrOut_ff;
  assign progCounter = pc_ff;
  assign softBrownoutEnable = soft_brownout_enable_ff;
endmodule // pcsa_core

//--- test/pcsa_core_assertions.sv
`timescale 1ns/1ps
module pcsa_core_assertions (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // watched ports
  input wire logic porEvent,
  input wire logic borEvent,
  input wire logic watchdogResetEvent,
  input wire logic masterClearEvent,
  input wire logic flowValid,
  input wire pcsa_pkg::pcsa_flow_s flowReq,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [pcsa_pkg::PC_W-1:0] progCounter,
  input wire logic softBrownoutEnable
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic noEv;
  logic [6:0] op;
  assign noEv = !(porEvent | borEvent | watchdogResetEvent | masterClearEvent);
  assign op = flowReq.op;
  sequence callSeq;
    flowValid && op == pcsa_pkg::PCSA_OP_CALL && noEv;
  endsequence
  sequence retSeq;
    flowValid && op == pcsa_pkg::PCSA_OP_RET && noEv;
  endsequence
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acked");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  AST_EVENT_CLEARS_PC: assert property (!noEv |=> progCounter == 13'h0000)
    else $error("pc not cleared");
  AST_STEP: assert property (flowValid && op == pcsa_pkg::PCSA_OP_STEP && noEv
    |=> progCounter == $past(progCounter) + 13'h0001) else $error("bad step");
  AST_JUMP_LOW: assert property (flowValid && noEv
    && (op == pcsa_pkg::PCSA_OP_JUMP || op == pcsa_pkg::PCSA_OP_CALL)
    |=> progCounter[10:0] == $past(flowReq.target)) else $error("bad jump");
  AST_WRPCL: assert property (flowValid && op == pcsa_pkg::PCSA_OP_WRPCL && noEv
    |=> progCounter[7:0] == $past(flowReq.lowByte)) else $error("bad low byte");
  AST_IRQ: assert property (flowValid && op == pcsa_pkg::PCSA_OP_IRQ && noEv
    |=> progCounter == $past(flowReq.vector)) else $error("bad vector");
  AST_CALL_RET: assert property (callSeq ##1 (!flowValid && noEv) [*2] ##1 retSeq
    |=> progCounter == $past(progCounter, 4) + 13'h0001) else $error("bad return");
  AST_POR_ENABLE: assert property (porEvent |=> softBrownoutEnable)
    else $error("enable not set");
endmodule // pcsa_core_assertions

bind pcsa_core pcsa_core_assertions i_chk (
  .clk_sys, .rst_n, .porEvent, .borEvent, .watchdogResetEvent, .masterClearEvent,
  .flowValid, .flowReq, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .progCounter, .softBrownoutEnable
);

//--- test/pcsa_core_tb.sv
`timescale 1ns/1ps
module pcsa_core_tb;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] evts = 4'h0;
  logic flowValid = 1'b0;
  pcsa_pkg::pcsa_flow_s flowReq = '0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [8:0] dataAddr;
  logic dataWrEn;
  logic [7:0] dataWrOut;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [12:0] progCounter;
  logic softBrownoutEnable;
  logic [7:0] lastWr;
  logic [31:0] d;
  int failures = 0;
  int checkCount = 0;
  int cycles = 0;
  int wrCount = 0;

  pcsa_core i_dut (
    .clk_sys, .rst_n, .porEvent(evts[0]), .borEvent(evts[1]),
    .watchdogResetEvent(evts[2]), .masterClearEvent(evts[3]),
    .flowValid, .flowReq, .dataRdIn(8'h5a), .dataAddr, .dataWrEn, .dataWrOut,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i(4'h1), .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .progCounter, .softBrownoutEnable
  );

  initial forever #2.5 clk_sys = ~clk_sys;

  task automatic complete_run;
    if (failures == 0 && checkCount > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 4000) begin
      failures++;
      complete_run();
    end
  end

  // counts indirect writes reaching data memory
  always @(posedge clk_sys)
    if (dataWrEn === 1'b1) begin
      wrCount++;
      lastWr = dataWrOut;
    end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checkCount++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] dat);
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= {24'h0, dat};
    do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
    d = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] adr, input logic [7:0] exp);
    wb(1'b0, adr, 8'h00);
    chk($sformatf("reg %h", adr), {24'h0, exp}, d);
  endtask

  task automatic pc(input logic [12:0] e);
    chk("progCounter", {19'h0, e}, {19'h0, progCounter});
  endtask

  task automatic flow(input pcsa_pkg::pcsa_op_e op, input logic [12:0] v);
    @(posedge clk_sys);
    flowValid <= 1'b1;
    flowReq <= '{op, v[10:0], v[7:0], v};
    @(posedge clk_sys);
    flowValid <= 1'b0;
    @(posedge clk_sys);
    #1;
  endtask

  task automatic pulse(input int k);
    @(posedge clk_sys);
    evts[k] <= 1'b1;
    @(posedge clk_sys);
    evts[k] <= 1'b0;
    @(posedge clk_sys);
    #1;
  endtask

  task automatic t_power;
    pc(13'h0000);
    rd(8'h8e, 8'h10);
    chk("softBrownoutEnable", 32'h1, {31'h0, softBrownoutEnable});
    wb(1'b1, 8'h8e, 8'hff);
    rd(8'h8e, 8'h13);
    pulse(2);
    rd(8'h8e, 8'h13);
    pulse(1);
    rd(8'h8e, 8'h12);
    wb(1'b1, 8'h8e, 8'h03);
    rd(8'h8e, 8'h03);
    chk("softBrownoutEnable", 32'h0, {31'h0, softBrownoutEnable});
    pulse(0);
    rd(8'h8e, 8'h10);
  endtask

  task automatic t_pc;
    wb(1'b1, 8'h0a, 8'h15);
    wb(1'b1, 8'h02, 8'h34);
    rd(8'h10, 8'h34);
    rd(8'h14, 8'h15);
    wb(1'b1, 8'h14, 8'h0e);
    pc(13'h1534);
    flow(pcsa_pkg::PCSA_OP_WRPCL, 13'h0077);
    pc(13'h1577);
    flow(pcsa_pkg::PCSA_OP_JUMP, 13'h0123);
    pc(13'h1123);
    flow(pcsa_pkg::PCSA_OP_STEP, 13'h0000);
    pc(13'h1124);
    flow(pcsa_pkg::PCSA_OP_CALL, 13'h07ff);
    pc(13'h17ff);
    flow(pcsa_pkg::PCSA_OP_RET, 13'h0000);
    pc(13'h1125);
    rd(8'h0a, 8'h15);
  endtask

  task automatic t_stack;
    for (int i = 1; i <= 9; i++) begin
      flow(pcsa_pkg::PCSA_OP_IRQ, 13'h1f00 | 13'(i));
      pc(13'h1f00 | 13'(i));
    end
    for (int j = 1; j <= 9; j++) begin
      flow(pcsa_pkg::PCSA_OP_RET, 13'h0000);
      pc(13'h1f00 + 13'(j < 9 ? 9 - j : 8));
    end
    rd(8'h0a, 8'h15);
    for (int k = 0; k < 4; k++) begin
      flow(pcsa_pkg::PCSA_OP_JUMP, 13'h0555);
      pulse(k);
      pc(13'h0000);
    end
  endtask

  task automatic t_ind;
    wb(1'b1, 8'h04, 8'h55);
    wb(1'b1, 8'h03, 8'h80);
    rd(8'h00, 8'h5a);
    chk("dataAddr", 32'h155, {23'h0, dataAddr});
    wb(1'b1, 8'h00, 8'h3c);
    rd(8'h04, 8'h55);
    chk("lastWr", 32'h3c, {24'h0, lastWr});
    wb(1'b1, 8'h04, 8'h00);
    rd(8'h00, 8'h00);
    wb(1'b1, 8'h00, 8'h99);
    rd(8'h40, 8'h00);
    chk("wrCount", 32'h1, wrCount);
    wb(1'b1, 8'h0a, 8'h16);
    flow(pcsa_pkg::PCSA_OP_WRPCL, 13'h0000);
    pc(13'h1600);
  endtask

  initial begin
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_power();
    t_pc();
    t_stack();
    t_ind();
    complete_run();
  end
endmodule // pcsa_core_tb
